//--- logic/pmucr_pkg.sv
// Package with register map, fields and encodings of the power mode and reset cause block
package pmucr_pkg;
	localparam logic [11:0] OFS_POWER_STATE_REQUEST     = 12'h000;
	localparam logic [11:0] OFS_BOOT_DEBUG_PORT_CONTROL = 12'h004;
	localparam logic [11:0] OFS_RESET_CAUSE_FLAGS       = 12'h008;
	localparam logic [11:0] OFS_RESET_CAUSE_CLEAR       = 12'h00C;
	localparam logic [11:0] OFS_WAKE_SOURCE_CLEAR       = 12'h010;
	localparam logic [11:0] OFS_POWER_STATE_REPORT      = 12'h014;
	localparam logic [11:0] OFS_SYSTEM_CLOCK_SOURCE     = 12'h018;
	localparam logic [11:0] OFS_WAKE_SOURCE_REPORT      = 12'h01C;
	localparam logic [11:0] OFS_BATTERY_DROOP_ACTION    = 12'h020;
	localparam logic [11:0] OFS_CLOCK_SOURCE_READY      = 12'h028;
	localparam logic [11:0] OFS_IRQ_STATUS              = 12'h100;
	localparam logic [11:0] OFS_IRQ_CLEAR               = 12'h104;
	localparam logic [11:0] OFS_IRQ_ENABLE              = 12'h108;

	localparam int CAUSE_WATCHDOG    = 5;
	localparam int CAUSE_LOCKUP      = 4;
	localparam int CAUSE_SOFTWARE    = 3;
	localparam int CAUSE_ANALOG_1V8  = 2;
	localparam int CAUSE_CORE_1V2    = 1;
	localparam int CAUSE_BATTERY     = 0;
	localparam int CAUSE_W           = 6;

	localparam int IRQ_BATTERY_DROOP = 0;
	localparam int IRQ_STATE_REQUEST = 1;
	localparam int IRQ_W             = 2;

	localparam int WAKE_W            = 5;
	localparam int CLK_RDY_W         = 7;
	localparam logic [6:0] CLK_RDY_MASK = 7'h5D;

	localparam int STATE_REQ_W       = 2;
	localparam int DEBUG_EN_BIT      = 0;
	localparam int SYSTEM_CLOCK_SOURCE_W         = 2;
	localparam int DROOP_ACT_BIT     = 0;
	localparam int WAKE_STATE_W      = 2;

	localparam logic [1:0] POWER_STATE_RESET = 2'h0;
	localparam logic       DEBUG_EN_RESET    = 1'h0;
	localparam logic [1:0] SYSTEM_CLOCK_SOURCE_RESET     = 2'h1;
	localparam logic       DROOP_ACT_RESET   = 1'h0;
	localparam logic       DROOP_ACT_RESETS  = 1'h1;

	typedef enum logic [1:0] {
		ACTIVE_OR_IDLE_STATE,
		LIGHT_SLEEP_STATE,
		DEEP_SLEEP_STATE,
		SHUTDOWN_STATE
	} pmucr_power_state_t;
endpackage

//--- logic/pmucr_top.sv
// Power mode request, debug port enable and sticky reset cause flags
`timescale 1ns/1ps
// Functional notes
// - Write-only power state request at offset 0x000, low two bits, reads zero
// - Request code 0 active/idle, 1 light sleep, 2 deep sleep, 3 shutdown
// - Bit 0 at 0x004 enables the debug test port, resets to 0
// - Cause bit 5 marks a watchdog reset
// - Cause bit 4 marks a processor core lockup reset
// - Cause bit 3 marks a software system reset request
// - Cause bit 2 marks a 1.8 V analog supply brown-out
// - Cause bit 1 marks a 1.2 V core supply brown-out
// - Cause bit 0 marks a battery brown-out
// - Cause flags read-only, zero after power-on, bits 31:6 read zero
// - Clear register at 0x00C clears matching cause flags, bits 5 to 0
// - Battery droop action bit: 0 interrupt, 1 chip reset and flag recorded
module pmucr_top (
	// Clock and power-on reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// Register port
	input  wire logic [11:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Reset and droop sources, one-cycle pulses
	input  wire logic        watchdog_event,
	input  wire logic        core_lockup_event,
	input  wire logic        software_reset_event,
	input  wire logic        analog_1v8_supply_droop,
	input  wire logic        core_1v2_supply_droop,
	input  wire logic        battery_droop,
	// Status from the rest of the unit
	input  wire logic [1:0]  wake_state_in,
	input  wire logic [4:0]  wake_source_in,
	input  wire logic [6:0]  clock_ready_in,
	// Control outputs
	output logic [1:0]       power_state_req,
	output logic             power_state_strobe,
	output logic             debug_port_enable,
	output logic [1:0]       sys_clk_sel,
	output logic [4:0]       wake_source_clear,
	output logic             chip_reset_req,
	output logic             irq
);
	// Register write decodes
	logic                          wr_state_req;
	logic                          wr_debug_ctrl;
	logic                          wr_system_clock_source;
	logic                          wr_droop_act;
	logic                          wr_wake_clr;
	logic                          wr_cause_clr;
	logic                          wr_irq_clr;
	logic                          wr_irq_en;
	// Reset cause flags
	logic [pmucr_pkg::CAUSE_W-1:0] cause_q;
	logic [pmucr_pkg::CAUSE_W-1:0] cause_set;
	logic [pmucr_pkg::CAUSE_W-1:0] cause_clr;
	// Battery droop routing
	logic                          droop_act_q;
	logic                          battery_resets;
	logic                          battery_interrupts;
	// Interrupt status and enable
	logic [pmucr_pkg::IRQ_W-1:0]   irq_stat_q;
	logic [pmucr_pkg::IRQ_W-1:0]   irq_stat_d;
	logic [pmucr_pkg::IRQ_W-1:0]   irq_en_q;
	logic [pmucr_pkg::IRQ_W-1:0]   irq_en_d;
	logic [pmucr_pkg::IRQ_W-1:0]   irq_set;
	logic [pmucr_pkg::IRQ_W-1:0]   irq_clr;
	// Read path
	logic [31:0]                   rdata_d;

	// One write decode per register, writes to read-only offsets fall through
	always_comb
	begin
		wr_state_req  = 1'b0;
		wr_debug_ctrl = 1'b0;
		wr_system_clock_source    = 1'b0;
		wr_droop_act  = 1'b0;
		wr_wake_clr   = 1'b0;
		wr_cause_clr  = 1'b0;
		wr_irq_clr    = 1'b0;
		wr_irq_en     = 1'b0;
		if (reg_wr)
		begin
			if (reg_addr == pmucr_pkg::OFS_POWER_STATE_REQUEST)
			begin
				wr_state_req = 1'b1;
			end
			else if (reg_addr == pmucr_pkg::OFS_BOOT_DEBUG_PORT_CONTROL)
			begin
				wr_debug_ctrl = 1'b1;
			end
			else if (reg_addr == pmucr_pkg::OFS_SYSTEM_CLOCK_SOURCE)
			begin
				wr_system_clock_source = 1'b1;
			end
			else if (reg_addr == pmucr_pkg::OFS_BATTERY_DROOP_ACTION)
			begin
				wr_droop_act = 1'b1;
			end
			else if (reg_addr == pmucr_pkg::OFS_WAKE_SOURCE_CLEAR)
			begin
				wr_wake_clr = 1'b1;
			end
			else if (reg_addr == pmucr_pkg::OFS_RESET_CAUSE_CLEAR)
			begin
				wr_cause_clr = 1'b1;
			end
			else if (reg_addr == pmucr_pkg::OFS_IRQ_CLEAR)
			begin
				wr_irq_clr = 1'b1;
			end
			else if (reg_addr == pmucr_pkg::OFS_IRQ_ENABLE)
			begin
				wr_irq_en = 1'b1;
			end
		end
	end

	// Battery droop goes either to a chip reset or to an interrupt
	always_comb
	begin
		battery_resets     = 1'b0;
		battery_interrupts = 1'b0;
		if (battery_droop)
		begin
			if (droop_act_q == pmucr_pkg::DROOP_ACT_RESETS)
			begin
				battery_resets = 1'b1;
			end
			else
			begin
				battery_interrupts = 1'b1;
			end
		end
	end

	// Source events mapped to their cause positions
	always_comb
	begin
		cause_set = '0;
		cause_set[pmucr_pkg::CAUSE_WATCHDOG]   = watchdog_event;
		cause_set[pmucr_pkg::CAUSE_LOCKUP]     = core_lockup_event;
		cause_set[pmucr_pkg::CAUSE_SOFTWARE]   = software_reset_event;
		cause_set[pmucr_pkg::CAUSE_ANALOG_1V8] = analog_1v8_supply_droop;
		cause_set[pmucr_pkg::CAUSE_CORE_1V2]   = core_1v2_supply_droop;
		cause_set[pmucr_pkg::CAUSE_BATTERY]    = battery_resets;
		cause_clr = '0;
		if (wr_cause_clr)
		begin
			cause_clr = reg_wdata[pmucr_pkg::CAUSE_W-1:0];
		end
	end

	// Sticky cause flags, cleared by power-on reset or by a write to the clear register, set wins over clear
	genvar gi;
	generate
		for (gi = 0; gi < pmucr_pkg::CAUSE_W; gi++)
		begin : g_cause
			always_ff @(posedge ref_clk or posedge rst)
			begin
				if (rst)
				begin
					cause_q[gi] <= 1'b0;
				end
				else if (cause_set[gi])
				begin
					cause_q[gi] <= 1'b1;
				end
				else if (cause_clr[gi])
				begin
					cause_q[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// Chip reset request for every recorded cause
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			chip_reset_req <= 1'b0;
		end
		else
		begin
			chip_reset_req <= |cause_set;
		end
	end

	// Power state request, written only
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			power_state_req <= pmucr_pkg::POWER_STATE_RESET;
		end
		else if (wr_state_req)
		begin
			power_state_req <= reg_wdata[pmucr_pkg::STATE_REQ_W-1:0];
		end
	end

	// Strobe that tells the power controller a new request stands
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			power_state_strobe <= 1'b0;
		end
		else
		begin
			power_state_strobe <= wr_state_req;
		end
	end

	// Debug test port enable
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			debug_port_enable <= pmucr_pkg::DEBUG_EN_RESET;
		end
		else if (wr_debug_ctrl)
		begin
			debug_port_enable <= reg_wdata[pmucr_pkg::DEBUG_EN_BIT];
		end
	end

	// System clock source select
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			sys_clk_sel <= pmucr_pkg::SYSTEM_CLOCK_SOURCE_RESET;
		end
		else if (wr_system_clock_source)
		begin
			sys_clk_sel <= reg_wdata[pmucr_pkg::SYSTEM_CLOCK_SOURCE_W-1:0];
		end
	end

	// Battery droop action
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			droop_act_q <= pmucr_pkg::DROOP_ACT_RESET;
		end
		else if (wr_droop_act)
		begin
			droop_act_q <= reg_wdata[pmucr_pkg::DROOP_ACT_BIT];
		end
	end

	// Wake source clear pulses
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			wake_source_clear <= '0;
		end
		else if (wr_wake_clr)
		begin
			wake_source_clear <= reg_wdata[pmucr_pkg::WAKE_W-1:0];
		end
		else
		begin
			wake_source_clear <= '0;
		end
	end

	// Interrupt events, set wins over clear
	always_comb
	begin
		irq_set = '0;
		irq_set[pmucr_pkg::IRQ_BATTERY_DROOP] = battery_interrupts;
		irq_set[pmucr_pkg::IRQ_STATE_REQUEST] = wr_state_req;
		irq_clr = '0;
		if (wr_irq_clr)
		begin
			irq_clr = reg_wdata[pmucr_pkg::IRQ_W-1:0];
		end
		irq_stat_d = irq_set | (irq_stat_q & ~irq_clr);
		irq_en_d = irq_en_q;
		if (wr_irq_en)
		begin
			irq_en_d = reg_wdata[pmucr_pkg::IRQ_W-1:0];
		end
	end

	// Sticky interrupt status
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			irq_stat_q <= '0;
		end
		else
		begin
			irq_stat_q <= irq_stat_d;
		end
	end

	// Interrupt enable
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			irq_en_q <= '0;
		end
		else
		begin
			irq_en_q <= irq_en_d;
		end
	end

	// Level interrupt, follows status and enable with no extra lag
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			irq <= 1'b0;
		end
		else
		begin
			irq <= |(irq_stat_d & irq_en_d);
		end
	end

	// Read decode, reserved bits and write-only registers read zero
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		if (reg_addr == pmucr_pkg::OFS_BOOT_DEBUG_PORT_CONTROL)
		begin
			rdata_d[pmucr_pkg::DEBUG_EN_BIT] = debug_port_enable;
		end
		else if (reg_addr == pmucr_pkg::OFS_RESET_CAUSE_FLAGS)
		begin
			rdata_d[pmucr_pkg::CAUSE_W-1:0] = cause_q;
		end
		else if (reg_addr == pmucr_pkg::OFS_POWER_STATE_REPORT)
		begin
			rdata_d[pmucr_pkg::WAKE_STATE_W-1:0] = wake_state_in;
		end
		else if (reg_addr == pmucr_pkg::OFS_SYSTEM_CLOCK_SOURCE)
		begin
			rdata_d[pmucr_pkg::SYSTEM_CLOCK_SOURCE_W-1:0] = sys_clk_sel;
		end
		else if (reg_addr == pmucr_pkg::OFS_WAKE_SOURCE_REPORT)
		begin
			rdata_d[pmucr_pkg::WAKE_W-1:0] = wake_source_in;
		end
		else if (reg_addr == pmucr_pkg::OFS_BATTERY_DROOP_ACTION)
		begin
			rdata_d[pmucr_pkg::DROOP_ACT_BIT] = droop_act_q;
		end
		else if (reg_addr == pmucr_pkg::OFS_CLOCK_SOURCE_READY)
		begin
			rdata_d[pmucr_pkg::CLK_RDY_W-1:0] = clock_ready_in & pmucr_pkg::CLK_RDY_MASK;
		end
		else if (reg_addr == pmucr_pkg::OFS_IRQ_STATUS)
		begin
			rdata_d[pmucr_pkg::IRQ_W-1:0] = irq_stat_q;
		end
		else if (reg_addr == pmucr_pkg::OFS_IRQ_ENABLE)
		begin
			rdata_d[pmucr_pkg::IRQ_W-1:0] = irq_en_q;
		end
	end

	// Read data stand only in the cycle after the read strobe
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			reg_rdata <= 32'h0000_0000;
		end
		else if (reg_rd)
		begin
			reg_rdata <= rdata_d;
		end
		else
		begin
			reg_rdata <= 32'h0000_0000;
		end
	end
endmodule

//--- verification/pmucr_monitor.sv
// Checker for the power mode and reset cause block
`timescale 1ns/1ps
module pmucr_monitor (
	// Watched ports
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        watchdog_event,
	input wire logic [1:0]  power_state_req,
	input wire logic        power_state_strobe,
	input wire logic        debug_port_enable,
	input wire logic        chip_reset_req
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	sequence s_wr_mode;
		reg_wr && reg_addr == 12'h000;
	endsequence
	sequence s_wr_dbg;
		reg_wr && reg_addr == 12'h004;
	endsequence
	a_mode_load: assert property (s_wr_mode |=> power_state_strobe
		&& power_state_req == $past(reg_wdata[1:0])) else $error("mode load");
	a_strobe_cause: assert property (power_state_strobe |->
		$past(reg_wr && reg_addr == 12'h000)) else $error("stray strobe");
	a_debug_load: assert property (s_wr_dbg |=>
		debug_port_enable == $past(reg_wdata[0])) else $error("debug load");
	a_debug_hold: assert property (!(reg_wr && reg_addr == 12'h004) |=>
		$stable(debug_port_enable)) else $error("debug moved");
	a_mode_rd_zero: assert property (reg_rd && reg_addr == 12'h000 |=>
		reg_rdata == 32'h0) else $error("mode readable");
	a_cause_upper: assert property (reg_rd && reg_addr == 12'h008 |=>
		reg_rdata[31:6] == 26'h0) else $error("upper cause bits");
	a_clear_rd: assert property (reg_rd && reg_addr == 12'h00C |=>
		reg_rdata == 32'h0) else $error("clear readable");
	a_wdog_reset: assert property (watchdog_event |=> chip_reset_req)
		else $error("no chip reset");
endmodule

//--- verification/pmucr_top_bench.sv
// Testbench for the power mode and reset cause block
`timescale 1ns/1ps
module pmucr_top_bench;
	logic        ref_clk = 1'h0;
	logic        rst = 1'h1;
	logic [11:0] reg_addr = 12'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'h0;
	logic        reg_rd = 1'h0;
	logic [5:0]  ev = 6'h0;
	logic [31:0] reg_rdata;
	logic [1:0]  power_state_req;
	logic [1:0]  sys_clk_sel;
	logic [4:0]  wake_source_clear;
	logic        power_state_strobe;
	logic        debug_port_enable;
	logic        chip_reset_req;
	logic        irq;
	int          error_cnt = 0;
	int          n_tests = 0;
	int          cyc = 0;
	pmucr_top uut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.watchdog_event(ev[5]), .core_lockup_event(ev[4]), .software_reset_event(ev[3]),
		.analog_1v8_supply_droop(ev[2]), .core_1v2_supply_droop(ev[1]),
		.battery_droop(ev[0]), .wake_state_in(2'h2), .wake_source_in(5'h15),
		.clock_ready_in(7'h7F), .power_state_req(power_state_req),
		.power_state_strobe(power_state_strobe), .debug_port_enable(debug_port_enable),
		.sys_clk_sel(sys_clk_sel), .wake_source_clear(wake_source_clear),
		.chip_reset_req(chip_reset_req), .irq(irq));
	always #4 ref_clk = ~ref_clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge ref_clk);
		reg_wr <= 1'h0;
		#1;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge ref_clk);
		reg_rd <= 1'h0;
		#1 chk(reg_rdata & m, e);
	endtask
	task automatic pulse(input int i);
		@(posedge ref_clk);
		ev <= 6'h01 << i;
		@(posedge ref_clk);
		ev <= 6'h00;
	endtask
	task automatic tally_and_finish;
		if (error_cnt == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			error_cnt++;
			$display("unexpected at %0t: timeout", $time);
			tally_and_finish;
		end
	end
	initial
	begin
		logic [31:0] e;
		e = 32'h0;
		repeat (2) @(posedge ref_clk);
		rst <= 1'h0;
		rd(12'h004, 32'h1, 32'h0);
		rd(12'h008, 32'hFFFFFFFF, 32'h0);
		for (int k = 0; k < 4; k++)
		begin
			wr(12'h000, 32'(k));
			chk(32'(power_state_req), 32'(k));
			chk(32'(power_state_strobe), 32'h1);
			rd(12'h000, 32'hFFFFFFFF, 32'h0);
		end
		rd(12'h100, 32'h2, 32'h2);
		wr(12'h004, 32'h1);
		rd(12'h004, 32'h1, 32'h1);
		for (int k = 5; k > 0; k--)
		begin
			pulse(k);
			#1 chk(32'(chip_reset_req), 32'h1);
			e = e | (32'h1 << k);
			rd(12'h008, 32'hFFFFFFFF, e);
		end
		pulse(0);
		#1 chk(32'(chip_reset_req), 32'h0);
		rd(12'h008, 32'hFFFFFFFF, 32'h3E);
		rd(12'h100, 32'h1, 32'h1);
		wr(12'h108, 32'h1);
		@(posedge ref_clk);
		#1 chk(32'(irq), 32'h1);
		wr(12'h104, 32'h1);
		@(posedge ref_clk);
		#1 chk(32'(irq), 32'h0);
		wr(12'h020, 32'h1);
		pulse(0);
		#1 chk(32'(chip_reset_req), 32'h1);
		rd(12'h008, 32'hFFFFFFFF, 32'h3F);
		wr(12'h008, 32'h0);
		rd(12'h008, 32'hFFFFFFFF, 32'h3F);
		wr(12'h00C, 32'h20);
		rd(12'h008, 32'hFFFFFFFF, 32'h1F);
		wr(12'h00C, 32'h1F);
		rd(12'h008, 32'hFFFFFFFF, 32'h0);
		rd(12'h00C, 32'hFFFFFFFF, 32'h0);
		rd(12'h0FC, 32'hFFFFFFFF, 32'h0);
		rd(12'h028, 32'hFFFFFFFF, 32'h5D);
		wr(12'h010, 32'h15);
		chk(32'(wake_source_clear), 32'h15);
		rd(12'h010, 32'hFFFFFFFF, 32'h0);
		chk(32'(wake_source_clear), 32'h0);
		rd(12'h014, 32'hFFFFFFFF, 32'h2);
		rd(12'h01C, 32'hFFFFFFFF, 32'h15);
		wr(12'h018, 32'h2);
		chk(32'(sys_clk_sel), 32'h2);
		pulse(3);
		@(posedge ref_clk);
		rst <= 1'h1;
		@(posedge ref_clk);
		rst <= 1'h0;
		rd(12'h008, 32'hFFFFFFFF, 32'h0);
		rd(12'h018, 32'hFFFFFFFF, 32'h1);
		chk(32'(sys_clk_sel), 32'h1);
		chk(32'(debug_port_enable), 32'h0);
		tally_and_finish;
	end
endmodule
bind pmucr_top pmucr_monitor mon (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.watchdog_event(watchdog_event), .power_state_req(power_state_req),
	.power_state_strobe(power_state_strobe), .debug_port_enable(debug_port_enable),
	.chip_reset_req(chip_reset_req));
